// ==== rtl/ppm_map.svh ====
// offsets, field positions, reset values and counts for the pin-mode block
`ifndef PPM_MAP_SVH
`define PPM_MAP_SVH

`define PPM_NUM_PINS        12
`define PPM_FIRST_PINS      4
`define PPM_SECOND_PINS     8
`define PPM_SECOND_BASE     4
`define PPM_MODE_W          2
`define PPM_CTRL_W          16
`define PPM_ADR_W           8
`define PPM_FIRST_CTRL_OFS  8'h00
`define PPM_SECOND_CTRL_OFS 8'h04
`define PPM_CTRL_RESET      16'h0000
`define PPM_RDATA_RESET     32'h0000_0000
`define PPM_LANE_LO         0
`define PPM_LANE_HI         1

`endif

// ==== rtl/ppm_pkg.sv ====
// types shared by the pin-mode block
package ppm_pkg;
`include "ppm_map.svh"

	typedef enum logic [1:0] {
		PPM_MODE_ALT      = 2'b00,
		PPM_MODE_OUT      = 2'b01,
		PPM_MODE_IN_PU    = 2'b10,
		PPM_MODE_IN_FLOAT = 2'b11
	} ppm_mode_t;

	typedef logic [`PPM_NUM_PINS-1:0] ppm_pins_t;
	typedef logic [`PPM_CTRL_W-1:0]   ppm_ctrl_t;
	typedef logic [`PPM_ADR_W-1:0]    ppm_adr_t;

endpackage

// ==== rtl/ppm_mode_if.sv ====
// per-pin mode codes and their decoded controls
`timescale 1ns/100ps
`include "ppm_map.svh"
interface ppm_mode_if;
	import ppm_pkg::*;

	ppm_mode_t mode [`PPM_NUM_PINS];
	ppm_pins_t alt_sel;
	ppm_pins_t out_en;
	ppm_pins_t in_en;
	ppm_pins_t pu_en;

	modport ctrl (output mode, input alt_sel, input out_en, input in_en, input pu_en);
	modport dec  (input mode, output alt_sel, output out_en, output in_en, output pu_en);
endinterface

// ==== rtl/ppm_pin_decode.sv ====
// decodes each pin's 2-bit mode into mux and pull-up controls
`timescale 1ns/100ps
`include "ppm_map.svh"
module ppm_pin_decode (
	ppm_mode_if.dec m
);
	import ppm_pkg::*;

	genvar i;
	generate
		for (i = 0; i < `PPM_NUM_PINS; i++) begin : g_pin
			always_comb begin
				m.alt_sel[i] = 1'b0;
				m.out_en[i]  = 1'b0;
				m.in_en[i]   = 1'b0;
				m.pu_en[i]   = 1'b0;
				case (m.mode[i])
					PPM_MODE_ALT: begin
						m.alt_sel[i] = 1'b1;
					end
					PPM_MODE_OUT: begin
						m.out_en[i] = 1'b1;
					end
					PPM_MODE_IN_PU: begin
						m.in_en[i] = 1'b1;
						m.pu_en[i] = 1'b1;
					end
					default: begin
						m.in_en[i] = 1'b1;
					end
				endcase
			end
		end
	endgenerate
endmodule

// ==== rtl/ppm_top.sv ====
// pin-mode control registers on wishbone with per-pin output muxing
// pins 0..3 are the first port's low pins, pins 4..11 the second port's pins 0..7
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/100ps
`include "ppm_map.svh"
module ppm_top (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire ppm_pkg::ppm_adr_t wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire ppm_pkg::ppm_pins_t alt_do_i,
	input  wire ppm_pkg::ppm_pins_t alt_oe_i,
	input  wire ppm_pkg::ppm_pins_t port_do_i,
	input  wire ppm_pkg::ppm_pins_t pad_di_i,
	output ppm_pkg::ppm_pins_t      pad_do_o,
	output ppm_pkg::ppm_pins_t      pad_oe_o,
	output ppm_pkg::ppm_pins_t      pad_pu_o,
	output ppm_pkg::ppm_pins_t      port_di_o,
	output ppm_pkg::ppm_pins_t      alt_di_o
);
	import ppm_pkg::*;

	ppm_ctrl_t   first_ctrl_q;
	ppm_ctrl_t   first_ctrl_d;
	ppm_ctrl_t   second_ctrl_q;
	ppm_ctrl_t   second_ctrl_d;
	logic        ack_q;
	logic        ack_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        req;
	logic        hit_first;
	logic        hit_second;
	logic        wr_take;
	logic        rd_start;
	ppm_pins_t   pad_do_q;
	ppm_pins_t   pad_do_d;
	ppm_pins_t   pad_oe_q;
	ppm_pins_t   pad_oe_d;
	ppm_pins_t   pad_pu_q;
	ppm_pins_t   pad_pu_d;
	ppm_pins_t   port_di_q;
	ppm_pins_t   port_di_d;
	ppm_pins_t   alt_di_q;
	ppm_pins_t   alt_di_d;

	ppm_mode_if  mode_bus ();

	// byte lanes beyond the low two hit nothing
	function automatic ppm_ctrl_t lane_merge(
		input ppm_ctrl_t   old,
		input logic [31:0] data,
		input logic [3:0]  sel
	);
		ppm_ctrl_t res;
		res = old;
		if (sel[`PPM_LANE_LO]) begin
			res[7:0] = data[7:0];
		end
		if (sel[`PPM_LANE_HI]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction

	// bus slave: one wait state, ack is a single-cycle pulse
	always_comb begin
		req        = wb_cyc_i & wb_stb_i;
		hit_first  = 1'b0;
		hit_second = 1'b0;
		if (wb_adr_i == `PPM_FIRST_CTRL_OFS) begin
			hit_first = 1'b1;
		end else if (wb_adr_i == `PPM_SECOND_CTRL_OFS) begin
			hit_second = 1'b1;
		end
		// write lands on the edge the master sees ack
		wr_take  = req & wb_we_i & ack_q;
		rd_start = req & ~wb_we_i & ~ack_q;
		ack_d    = req & ~ack_q;
		rdata_d  = rdata_q;
		if (rd_start) begin
			if (hit_first) begin
				rdata_d = {16'h0000, first_ctrl_q};
			end else if (hit_second) begin
				rdata_d = {16'h0000, second_ctrl_q};
			end else begin
				rdata_d = `PPM_RDATA_RESET;
			end
		end
		first_ctrl_d  = first_ctrl_q;
		second_ctrl_d = second_ctrl_q;
		if (wr_take && hit_first) begin
			first_ctrl_d = lane_merge(first_ctrl_q, wb_dat_i, wb_sel_i);
		end else if (wr_take && hit_second) begin
			second_ctrl_d = lane_merge(second_ctrl_q, wb_dat_i, wb_sel_i);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			first_ctrl_q  <= `PPM_CTRL_RESET;
			second_ctrl_q <= `PPM_CTRL_RESET;
			ack_q         <= 1'b0;
			rdata_q       <= `PPM_RDATA_RESET;
		end else begin
			first_ctrl_q  <= first_ctrl_d;
			second_ctrl_q <= second_ctrl_d;
			ack_q         <= ack_d;
			rdata_q       <= rdata_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

	// register fields to per-pin modes, then per-pin mux
	genvar i;
	generate
		for (i = 0; i < `PPM_NUM_PINS; i++) begin : g_pin
			if (i < `PPM_FIRST_PINS) begin : g_first
				assign mode_bus.mode[i] = ppm_mode_t'(first_ctrl_q[2*i+1 -: 2]);
			end else begin : g_second
				assign mode_bus.mode[i] =
					ppm_mode_t'(second_ctrl_q[2*(i-`PPM_SECOND_BASE)+1 -: 2]);
			end
			// peripheral or port drives the pad
			assign pad_do_d[i] = (mode_bus.alt_sel[i] & alt_do_i[i]) |
			                     (mode_bus.out_en[i] & port_do_i[i]);
			assign pad_oe_d[i] = (mode_bus.alt_sel[i] & alt_oe_i[i]) | mode_bus.out_en[i];
			// pull-up only in its own input mode
			assign pad_pu_d[i]  = mode_bus.pu_en[i];
			// port sees the pad in output mode and in either input mode
			assign port_di_d[i] = (mode_bus.in_en[i] | mode_bus.out_en[i]) & pad_di_i[i];
			assign alt_di_d[i]  = mode_bus.alt_sel[i] & pad_di_i[i];
		end
	endgenerate

	ppm_pin_decode u_decode (
		.m (mode_bus.dec)
	);

	// one cycle of pipe so pads never see decode glitches
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pad_do_q  <= '0;
			pad_oe_q  <= '0;
			pad_pu_q  <= '0;
			port_di_q <= '0;
			alt_di_q  <= '0;
		end else begin
			pad_do_q  <= pad_do_d;
			pad_oe_q  <= pad_oe_d;
			pad_pu_q  <= pad_pu_d;
			port_di_q <= port_di_d;
			alt_di_q  <= alt_di_d;
		end
	end

	assign pad_do_o  = pad_do_q;
	assign pad_oe_o  = pad_oe_q;
	assign pad_pu_o  = pad_pu_q;
	assign port_di_o = port_di_q;
	assign alt_di_o  = alt_di_q;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// bus handshake shape
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	ack_wait_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("ack not given one cycle after request");

	reset_clear_a: assert property ($past(rst_i) |-> (first_ctrl_q == 16'h0000 &&
		second_ctrl_q == 16'h0000 && pad_oe_o == 12'h000 && pad_pu_o == 12'h000))
		else $error("state not clear after reset");

	// full write lands in second register
	write_store_a: assert property ((req && wb_we_i && ack_q && hit_second &&
		wb_sel_i == 4'h3) |=> second_ctrl_q == $past(wb_dat_i[15:0]))
		else $error("second register write lost");

	read_back_a: assert property ((req && !wb_we_i && !ack_q && hit_second) |=>
		(wb_ack_o && wb_dat_o == {16'h0000, $past(second_ctrl_q)}))
		else $error("readback differs from register");

	alt_route_a: assert property ((!rst_i && second_ctrl_q[1:0] == 2'b00) |=>
		(pad_oe_o[4] == $past(alt_oe_i[4]) && pad_do_o[4] == $past(alt_do_i[4])))
		else $error("alternate function not routed");

	out_drive_a: assert property ((first_ctrl_q[1:0] == 2'b01) |=>
		(pad_oe_o[0] && pad_do_o[0] == $past(port_do_i[0]) && !pad_pu_o[0]))
		else $error("port output not driven");

	pullup_on_a: assert property ((second_ctrl_q[15:14] == 2'b10) |=>
		(pad_pu_o[11] && !pad_oe_o[11] && port_di_o[11] == $past(pad_di_i[11])))
		else $error("pull-up input mode wrong");

	pullup_off_a: assert property ((first_ctrl_q[7:6] == 2'b11) |=>
		(!pad_pu_o[3] && !pad_oe_o[3] && !alt_di_o[3]))
		else $error("floating input mode wrong");

	write_then_read_c: cover property ((wr_take && hit_second) ##2 (rd_start && hit_second));
	pullup_mode_c: cover property (pad_pu_o[11] && pad_pu_o[0]);
	out_mode_c: cover property (pad_oe_o[0] && !pad_pu_o[0] ##1 !pad_oe_o[0]);
endmodule

// ==== bench/ppm_pad_model.sv ====
// pad model: the level each pad shows to the block
`timescale 1ns/100ps
module ppm_pad_model (
	input  wire logic               clk_i,
	input  wire ppm_pkg::ppm_pins_t pad_do_i,
	input  wire ppm_pkg::ppm_pins_t pad_oe_i,
	input  wire ppm_pkg::ppm_pins_t pad_pu_i,
	output ppm_pkg::ppm_pins_t      pad_di_o
);
	import ppm_pkg::*;
	// undriven pads without pull-up wander so a stale level never passes
	ppm_pins_t flt_q = 12'h5a5;
	always_ff @(posedge clk_i) begin
		flt_q <= ~flt_q;
	end
	always_comb begin
		pad_di_o = (pad_oe_i & pad_do_i) | (~pad_oe_i & (pad_pu_i | flt_q));
	end
endmodule

// ==== bench/ppm_top_tb_top.sv ====
// random and corner tests of the pin-mode block
`timescale 1ns/100ps
module ppm_top_tb_top;
	import ppm_pkg::*;
	logic        clk_i = 0;
	logic        rst_i = 1;
	logic        cyc   = 0;
	logic        stb   = 0;
	logic        we    = 0;
	ppm_adr_t    adr   = 8'h00;
	logic [3:0]  sel   = 4'h0;
	logic [31:0] dati  = 32'h0;
	logic [31:0] dato;
	logic        ack;
	ppm_pins_t   a_do  = 12'h000;
	ppm_pins_t   a_oe  = 12'h000;
	ppm_pins_t   p_do  = 12'h000;
	ppm_pins_t   pad_di, pad_do, pad_oe, pad_pu, port_di, alt_di;
	ppm_ctrl_t   r0    = 16'h0000;
	ppm_ctrl_t   r1    = 16'h0000;
	integer      seed  = 32'h2dc57d7e;
	integer      err_total = 0;
	integer      num_checks = 0;

	initial forever #12.5 clk_i = ~clk_i;

	ppm_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dati),
		.wb_dat_o(dato), .wb_ack_o(ack), .alt_do_i(a_do), .alt_oe_i(a_oe),
		.port_do_i(p_do), .pad_di_i(pad_di), .pad_do_o(pad_do), .pad_oe_o(pad_oe),
		.pad_pu_o(pad_pu), .port_di_o(port_di), .alt_di_o(alt_di));

	ppm_pad_model pad (.clk_i(clk_i), .pad_do_i(pad_do), .pad_oe_i(pad_oe),
		.pad_pu_i(pad_pu), .pad_di_o(pad_di));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic acc(input logic w, input ppm_adr_t a, input logic [3:0] s,
		input logic [15:0] d);
		int n;
		logic [31:0] q;
		ppm_ctrl_t m;
		n = 0;
		m = (a == 8'h00) ? r0 : (a == 8'h04) ? r1 : 16'h0000;
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		sel <= s;
		dati <= {16'hffff, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1);
		q = dato;
		cyc <= 0;
		stb <= 0;
		chk(32'(n), 32'h2);
		if (w) begin
			if (s[0]) m[7:0] = d[7:0];
			if (s[1]) m[15:8] = d[15:8];
			if (a == 8'h00) r0 = m;
			if (a == 8'h04) r1 = m;
		end else begin
			chk(q, {16'h0000, m});
		end
	endtask

	function automatic ppm_mode_t md(int i);
		return ppm_mode_t'(i < 4 ? r0[2*i +: 2] : r1[2*(i-4) +: 2]);
	endfunction

	// outputs follow mode and the inputs seen one edge earlier
	task automatic pins(input int cyc_n);
		ppm_pins_t ed, eo, ep, epd, ead, dm, pd;
		for (int c = 0; c < cyc_n; c++) begin
			@(posedge clk_i);
			pd = pad_di;
			for (int i = 0; i < 12; i++) begin
				ed[i] = md(i) == PPM_MODE_ALT ? a_do[i] : p_do[i];
				eo[i] = md(i) == PPM_MODE_ALT ? a_oe[i] : md(i) == PPM_MODE_OUT;
				ep[i] = md(i) == PPM_MODE_IN_PU;
				ead[i] = md(i) == PPM_MODE_ALT && pd[i];
				epd[i] = md(i) != PPM_MODE_ALT && pd[i];
				dm[i] = md(i) inside {PPM_MODE_ALT, PPM_MODE_OUT};
			end
			a_do <= 12'($random(seed));
			a_oe <= 12'($random(seed));
			p_do <= 12'($random(seed));
			#1;
			if (c > 2) begin
				chk(pad_do & dm, ed & dm);
				chk(pad_oe, eo);
				chk(pad_pu, ep);
				chk(port_di, epd);
				chk(alt_di, ead);
			end
		end
	endtask

	initial begin
		ppm_adr_t a;
		logic [3:0] s;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		acc(0, 8'h00, 4'hf, 16'h0000);
		acc(0, 8'h04, 4'hf, 16'h0000);
		pins(6);
		for (int k = 0; k < 4; k++) begin
			acc(1, 8'h00, 4'h3, {8{k[1:0]}});
			acc(1, 8'h04, 4'h3, {8{k[1:0]}});
			pins(8);
		end
		// unmapped offsets and empty byte enables among the draws
		repeat (40) begin
			a = ppm_adr_t'(($random(seed) & 3) * 4);
			s = 4'($random(seed));
			acc(1, a, s, 16'($random(seed)));
			acc(0, a, 4'hf, 16'h0000);
			acc(0, a, 4'hf, 16'h0000);
			pins(5);
		end
		@(posedge clk_i);
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		r0 = 16'h0000;
		r1 = 16'h0000;
		acc(0, 8'h00, 4'hf, 16'h0000);
		acc(0, 8'h04, 4'hf, 16'h0000);
		close_out();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		close_out();
	end
endmodule
